// ===== rtl/wdg_timebase_regs.svh
/*
 * Register offsets, field positions, reset values and timing counts for the
 * watchdog with its time-base timer. Assumes a 125 MHz oscillator clock.
 */
// Function
// RULE_01 - Reset loads counter 7Fh, watchdog disabled.
// RULE_02 - Activate bit set by software, cleared by reset.
// RULE_03 - Counter decrements every 16384 oscillator cycles.
// RULE_04 - Rollover 40h to 3Fh resets when enabled.
// RULE_05 - Hardware option keeps watchdog always active.
// RULE_06 - Plain halt: one decrement, then counter stops.
// RULE_07 - External wake from halt delays counting restart.
// RULE_08 - Reset from halt disables unless hardware option.
// RULE_09 - Halt with halt-reset option generates reset.
// RULE_10 - Halt with irq enable: active-halt, counter stops.
// RULE_11 - Active-halt exit: interrupt immediate, reset delayed.
// RULE_12 - Time-base: four periods, select, enable, flag.
// RULE_13 - Time-base irq enable turns halt into active-halt.
// RULE_14 - Time-base runs in wait, interrupt exits wait.
// RULE_15 - Active-halt: time-base runs, registers frozen, wakes.
// RULE_16 - Full halt freezes time-base counter and registers.
// RULE_17 - Interrupt needs enable set and mask inactive.
// RULE_18 - Time-base wakes active-halt and wait, never halt.
// RULE_19 - Software refreshes counter before halt when enabled.
// RULE_20 - Counter keeps decrementing while watchdog inactive.
// RULE_21 - Activate with top bit clear resets at once.
// RULE_22 - Flag set on period end, cleared by read.
// RULE_23 - Period change applies at end of period.
// RULE_24 - Slow and wait leave watchdog unchanged.
// RULE_25 - Watchdog has no interrupt, only reset request.
`ifndef WDG_TIMEBASE_REGS_SVH
`define WDG_TIMEBASE_REGS_SVH

`define WDG_CTRL_OFS 8'h24
`define TB_CSR_OFS 8'h28
`define WDG_CTRL_RST 8'h7f
`define WDG_ACT_BIT 7
`define WDG_TOP_BIT 6
`define TB_SEL_LSB 2
`define TB_IE_BIT 1
`define TB_FLAG_BIT 0
`define WDG_TRIGGER 7'h40

`define WDG_PRESCALE 16384
`define TB_PERIOD_0 16000
`define TB_PERIOD_1 32000
`define TB_PERIOD_2 80000
`define TB_PERIOD_3 200000
`define WAKE_DLY_SHORT 256
`define WAKE_DLY_LONG 4096

`define CLK_PERIOD_NS 8
`define WDG_RST_PULSE_NS 500
`define WDG_RST_PULSE_CYC ((`WDG_RST_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== rtl/wdg_timebase_pkg.sv
/*
 * Types for the watchdog with time-base timer: APB carriers, modes, state.
 * Assumes the offsets and counts of wdg_timebase_regs.svh.
 */
package wdg_timebase_pkg;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} apb_rsp_t;

	typedef enum logic [2:0] {
		st_run,
		st_halt_pend,
		st_halt,
		st_active_halt,
		st_delay
	} mode_t;

	typedef struct packed {
		logic [2:0] opt_meta;
		logic [2:0] opt_sync;
		logic act;
		logic [6:0] cnt;
		logic [15:0] pre;
		logic [17:0] tbc;
		logic [1:0] tb_sel;
		logic [1:0] tb_act;
		logic timebase_irq_enable;
		logic timebase_event_flag;
		mode_t mode;
		logic [11:0] dly;
		logic [6:0] rpc;
		logic rst_req;
		logic [31:0] rdata;
	} wdg_state_t;

endpackage : wdg_timebase_pkg

// ===== rtl/wdg_timebase.sv
/*
 * Watchdog with free-running 7-bit down-counter and a time-base timer that
 * selects active-halt. Registers on APB. Assumes halt_req, ext_wake and
 * irq_mask come from CPU logic on clk; option straps come from pins.
 */
`timescale 1ns/100ps
`default_nettype none
`include "wdg_timebase_regs.svh"

module wdg_timebase #(
	parameter int PRESCALE = `WDG_PRESCALE,
	parameter int TB_P0 = `TB_PERIOD_0,
	parameter int TB_P1 = `TB_PERIOD_1,
	parameter int TB_P2 = `TB_PERIOD_2,
	parameter int TB_P3 = `TB_PERIOD_3
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Register bus
	input wire wdg_timebase_pkg::apb_req_t apb_req,
	output wdg_timebase_pkg::apb_rsp_t apb_rsp,
	// Option straps
	input wire logic hw_wdg_opt,
	input wire logic halt_reset_option,
	input wire logic wake_dly_long_opt,
	// CPU side
	input wire logic halt_req,
	input wire logic ext_wake,
	input wire logic irq_mask,
	// Results
	output logic mcu_reset_req,
	output logic timebase_irq,
	output logic halted,
	output logic active_halted
);

	// ---------------------------------------------------------------
	// Reset release
	// ---------------------------------------------------------------
	logic rst_meta_b;
	logic rst_sync_b;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta_b <= 1'b0;
			rst_sync_b <= 1'b0;
		end else begin
			rst_meta_b <= 1'b1;
			rst_sync_b <= rst_meta_b;
		end
	end

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	// Counting starts in the delay state so that a reset, including one
	// that ends active-halt, restarts the counter only after the delay.
	localparam wdg_timebase_pkg::wdg_state_t RESET_STATE = '{
		opt_meta: 3'h0, opt_sync: 3'h0, act: 1'b0,
		cnt: 7'(`WDG_CTRL_RST), pre: 16'h0000, tbc: 18'h00000,
		tb_sel: 2'h0, tb_act: 2'h0, timebase_irq_enable: 1'b0, timebase_event_flag: 1'b0,
		mode: wdg_timebase_pkg::st_delay, dly: 12'h000, rpc: 7'h00,
		rst_req: 1'b0, rdata: 32'h00000000};

	wdg_timebase_pkg::wdg_state_t state_reg;
	wdg_timebase_pkg::wdg_state_t state_next;

	logic setup;
	logic access;
	logic hit_ctl;
	logic hit_tb;
	logic wr_ctl;
	logic wr_tb;
	logic rd_tb;
	logic hw_on;
	logic halt_rst_on;
	logic dly_long;
	logic wd_on;
	logic counting;
	logic wd_tick;
	logic tb_run;
	logic tb_tick;
	logic [17:0] tb_last;
	logic [11:0] dly_last;
	logic trip;

	assign setup = apb_req.psel && !apb_req.penable;
	assign access = apb_req.psel && apb_req.penable;
	assign hit_ctl = apb_req.paddr == `WDG_CTRL_OFS;
	assign hit_tb = apb_req.paddr == `TB_CSR_OFS;
	assign wr_ctl = access && apb_req.pwrite && hit_ctl;
	assign wr_tb = access && apb_req.pwrite && hit_tb;
	assign rd_tb = access && !apb_req.pwrite && hit_tb;

	assign hw_on = state_reg.opt_sync[0];
	assign halt_rst_on = state_reg.opt_sync[1];
	assign dly_long = state_reg.opt_sync[2];
	assign wd_on = state_reg.act || hw_on; // [RULE_05]

	// The counter runs whatever the activate bit; slow and wait are not
	// seen here at all, so they cannot disturb it. [RULE_20] [RULE_24]
	assign counting = state_reg.mode == wdg_timebase_pkg::st_run ||
		state_reg.mode == wdg_timebase_pkg::st_halt_pend;
	assign wd_tick = counting && state_reg.pre == 16'(PRESCALE - 1); // [RULE_03]

	// The time-base stops only in full halt; it runs in wait and in
	// active-halt. [RULE_14] [RULE_15] [RULE_16]
	assign tb_run = state_reg.mode != wdg_timebase_pkg::st_halt &&
		state_reg.mode != wdg_timebase_pkg::st_halt_pend;
	assign tb_tick = tb_run && state_reg.tbc == tb_last;
	assign dly_last = dly_long ? 12'(`WAKE_DLY_LONG - 1) : 12'(`WAKE_DLY_SHORT - 1);

	always_comb begin
		case (state_reg.tb_act) // [RULE_12]
			2'h0: tb_last = 18'(TB_P0 - 1);
			2'h1: tb_last = 18'(TB_P1 - 1);
			2'h2: tb_last = 18'(TB_P2 - 1);
			default: tb_last = 18'(TB_P3 - 1);
		endcase
	end

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		trip = 1'b0;
		state_next.opt_meta = {wake_dly_long_opt, halt_reset_option, hw_wdg_opt};
		state_next.opt_sync = state_reg.opt_meta;

		if (counting) begin
			state_next.pre = wd_tick ? 16'h0000 : state_reg.pre + 16'h0001;
		end
		if (wd_tick) begin
			state_next.cnt = state_reg.cnt - 7'h01; // [RULE_03]
			if (state_reg.mode == wdg_timebase_pkg::st_run && wd_on &&
				state_reg.cnt == `WDG_TRIGGER) begin
				trip = 1'b1; // [RULE_04]
			end
			if (state_reg.mode == wdg_timebase_pkg::st_halt_pend) begin
				state_next.mode = wdg_timebase_pkg::st_halt; // [RULE_06]
			end
		end

		// A refresh in the tick cycle wins over the decrement, not over a rollover trip; the prescaler is left running,
		// which is why a timeout varies by up to one tick.
		if (wr_ctl) begin
			state_next.act = state_reg.act | apb_req.pwdata[`WDG_ACT_BIT]; // [RULE_02]
			state_next.cnt = apb_req.pwdata[6:0];
			if ((apb_req.pwdata[`WDG_ACT_BIT] || wd_on) && !apb_req.pwdata[`WDG_TOP_BIT]) begin
				trip = 1'b1; // [RULE_21]
			end
		end

		case (state_reg.mode)
			wdg_timebase_pkg::st_run: begin
				if (halt_req) begin
					if (state_reg.timebase_irq_enable) begin
						state_next.mode = wdg_timebase_pkg::st_active_halt; // [RULE_10] [RULE_13]
					end else if (halt_rst_on) begin
						trip = 1'b1; // [RULE_09]
					end else begin
						state_next.mode = wdg_timebase_pkg::st_halt_pend; // [RULE_06]
					end
				end
			end
			wdg_timebase_pkg::st_halt_pend, wdg_timebase_pkg::st_halt: begin
				if (ext_wake) begin
					state_next.mode = wdg_timebase_pkg::st_delay; // [RULE_07]
					state_next.dly = 12'h000;
				end
			end
			wdg_timebase_pkg::st_active_halt: begin
				if (ext_wake || timebase_irq) begin
					state_next.mode = wdg_timebase_pkg::st_run; // [RULE_11] [RULE_18]
				end
			end
			wdg_timebase_pkg::st_delay: begin
				state_next.dly = state_reg.dly + 12'h001;
				if (state_reg.dly == dly_last) begin
					state_next.mode = wdg_timebase_pkg::st_run; // [RULE_07] [RULE_11]
				end
			end
			default: begin
				state_next.mode = wdg_timebase_pkg::st_run;
			end
		endcase

		if (tb_run) begin
			state_next.tbc = tb_tick ? 18'h00000 : state_reg.tbc + 18'h00001;
		end
		if (tb_tick) begin
			state_next.tb_act = state_reg.tb_sel; // [RULE_23]
		end
		if (wr_tb && state_reg.mode != wdg_timebase_pkg::st_active_halt) begin
			state_next.tb_sel = apb_req.pwdata[`TB_SEL_LSB +: 2]; // [RULE_15]
			state_next.timebase_irq_enable = apb_req.pwdata[`TB_IE_BIT];
		end
		if (rd_tb) begin
			state_next.timebase_event_flag = 1'b0; // [RULE_22]
		end
		if (tb_tick) begin
			state_next.timebase_event_flag = 1'b1; // [RULE_22]
		end

		if (setup) begin
			state_next.rdata = 32'h00000000;
			if (hit_ctl) begin
				state_next.rdata[7:0] = {state_reg.act, state_reg.cnt};
			end else if (hit_tb) begin
				state_next.rdata[3:0] = {state_reg.tb_sel, state_reg.timebase_irq_enable, state_reg.timebase_event_flag};
			end
		end

		// The request is held for the documented pulse; the system reset
		// then clears this block, which also clears activate. [RULE_08]
		if (trip) begin
			state_next.rst_req = 1'b1;
			state_next.rpc = 7'(`WDG_RST_PULSE_CYC - 1);
		end else if (state_reg.rst_req) begin
			if (state_reg.rpc == 7'h00) begin
				state_next.rst_req = 1'b0;
			end else begin
				state_next.rpc = state_reg.rpc - 7'h01;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			state_reg <= RESET_STATE; // [RULE_01]
		end else begin
			state_reg <= state_next;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	// The reset request is the only watchdog output. [RULE_25]
	assign mcu_reset_req = state_reg.rst_req;
	assign timebase_irq = state_reg.timebase_event_flag && state_reg.timebase_irq_enable && !irq_mask; // [RULE_17]
	assign halted = state_reg.mode == wdg_timebase_pkg::st_halt ||
		state_reg.mode == wdg_timebase_pkg::st_halt_pend;
	assign active_halted = state_reg.mode == wdg_timebase_pkg::st_active_halt;
	assign apb_rsp.pready = 1'b1;
	assign apb_rsp.pslverr = access && !hit_ctl && !hit_tb;
	assign apb_rsp.prdata = state_reg.rdata;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_sync_b);

	chk_reset_value: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_01]
		$rose(rst_sync_b) |-> state_reg.cnt == 7'h7f && !state_reg.act)
		else $error("Counter or activate wrong after reset.");
	chk_activate_sticky: assert property (!$fell(state_reg.act)) // [RULE_02]
		else $error("Activate bit cleared without reset.");
	chk_tick_decrement: assert property (wd_tick && !wr_ctl |=> // [RULE_03]
		state_reg.cnt == $past(state_reg.cnt) - 7'h01)
		else $error("Counter did not decrement on tick.");
	chk_rollover_reset: assert property (state_reg.mode == wdg_timebase_pkg::st_run && // [RULE_04]
		wd_tick && state_reg.cnt == 7'h40 && state_reg.act |=> mcu_reset_req [*2])
		else $error("No reset on rollover.");
	chk_hw_option: assert property (state_reg.mode == wdg_timebase_pkg::st_run && // [RULE_05]
		wd_tick && state_reg.cnt == 7'h40 && hw_on |=> mcu_reset_req)
		else $error("Hardware option did not reset.");
	chk_halt_freeze: assert property (state_reg.mode == wdg_timebase_pkg::st_halt && // [RULE_06]
		!wr_ctl |=> $stable(state_reg.cnt) && !mcu_reset_req)
		else $error("Counter moved in halt.");
	chk_halt_reset: assert property (state_reg.mode == wdg_timebase_pkg::st_run && // [RULE_09]
		halt_req && !state_reg.timebase_irq_enable && halt_rst_on |=> mcu_reset_req)
		else $error("Halt did not reset.");
	chk_ahalt_stop: assert property (active_halted && !wr_ctl |=> // [RULE_10]
		$stable(state_reg.cnt) && $stable(state_reg.pre))
		else $error("Counter moved in active-halt.");
	chk_sw_reset: assert property (wr_ctl && apb_req.pwdata[7] && !apb_req.pwdata[6] |=> // [RULE_21]
		mcu_reset_req ##1 mcu_reset_req)
		else $error("Software reset not issued.");
	chk_flag_set: assert property (tb_tick |=> state_reg.timebase_event_flag) // [RULE_22]
		else $error("Time-base flag not set.");
	chk_ahalt_wake: assert property (active_halted && timebase_irq |=> // [RULE_18]
		state_reg.mode == wdg_timebase_pkg::st_run)
		else $error("Time-base did not end active-halt.");
	chk_wake_delay: assert property (state_reg.mode == wdg_timebase_pkg::st_halt && // [RULE_07]
		ext_wake |=> state_reg.mode == wdg_timebase_pkg::st_delay ##1 !counting)
		else $error("Halt wake skipped the delay.");

endmodule : wdg_timebase
`default_nettype wire

// ===== verif/wdg_timebase_tb_top.sv
/*
 * Self-checking bench for the watchdog with time-base timer.
 * Assumes short prescale and period counts set below; straps and CPU pins are driven here.
 */
`timescale 1ns/100ps
`default_nettype none

module wdg_timebase_tb_top;
	localparam int TBP[4] = '{20, 24, 28, 32};
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	wdg_timebase_pkg::apb_req_t req = '0;
	wdg_timebase_pkg::apb_rsp_t rsp;
	logic hw_opt = 1'b0;
	logic hr_opt = 1'b0;
	logic dl_opt = 1'b0;
	logic halt_req = 1'b0;
	logic ext_wake = 1'b0;
	logic irq_mask = 1'b1;
	logic mcu_reset_req;
	logic timebase_irq;
	logic halted;
	logic active_halted;
	int bad_count = 0;
	int samples_checked = 0;
	int cyc = 0;
	int t0;
	int n;
	logic [31:0] seed = 32'h5f52;
	logic [31:0] rd;
	logic [31:0] r;
	logic err;
	logic [6:0] v;

	wdg_timebase #(.PRESCALE(16), .TB_P0(TBP[0]), .TB_P1(TBP[1]), .TB_P2(TBP[2]), .TB_P3(TBP[3]))
	wdg_timebase_inst (.clk(clk), .rst_b(rst_b), .apb_req(req), .apb_rsp(rsp), .hw_wdg_opt(hw_opt),
		.halt_reset_option(hr_opt), .wake_dly_long_opt(dl_opt), .halt_req(halt_req), .ext_wake(ext_wake),
		.irq_mask(irq_mask), .mcu_reset_req(mcu_reset_req), .timebase_irq(timebase_irq),
		.halted(halted), .active_halted(active_halted));

	always #4 clk = ~clk;

	// A hang ends the run as a failure.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			bad_count++;
			results();
		end
	end

	// ------
	// Helpers
	// ------
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	function automatic logic [31:0] ok(input logic b);
		return {31'h0, b};
	endfunction : ok

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
		@(posedge clk);
		req.penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (rsp.pready !== 1'b1);
		rd = rsp.prdata;
		err = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask : apb

	// Waits at falling edges: 0 for reset request, 1 for time-base irq, 2 for active-halt exit.
	task automatic wait_for(input int which, input int lim, output int c);
		c = 0;
		do begin
			@(negedge clk);
			c++;
		end while (c < lim && !(which == 0 ? mcu_reset_req === 1'b1 :
			which == 1 ? timebase_irq === 1'b1 : active_halted === 1'b0));
	endtask : wait_for

	task automatic sys_reset();
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
	endtask : sys_reset

	task automatic pulse(input logic wake);
		@(posedge clk);
		halt_req <= ~wake;
		ext_wake <= wake;
		@(posedge clk);
		halt_req <= 1'b0;
		ext_wake <= 1'b0;
	endtask : pulse

	task automatic results();
		$display("Comparisons %0d, mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : results

	// ------
	// Sequence
	// ------
	initial begin
		sys_reset();
		apb(1'b0, 8'h24, 0);
		chk(rd, 32'h7f);
		apb(1'b0, 8'h28, 0);
		chk(rd, 32'h0);
		apb(1'b0, 8'h30, 0);
		chk(ok(err), 1);
		repeat (300) @(posedge clk);
		// The prescaler phase is unknown after a write, so one tick of slack is allowed.
		repeat (3) begin
			r = rnd();
			v = 7'h50 | (r[6:0] & 7'h2f);
			apb(1'b1, 8'h24, {25'h0, v});
			repeat (128) @(posedge clk);
			apb(1'b0, 8'h24, 0);
			chk(ok(rd[7:0] == {1'b0, v - 7'd8} || rd[7:0] == {1'b0, v - 7'd9}), 1);
		end
		apb(1'b1, 8'h24, 32'h42);
		wait_for(0, 80, n);
		chk(n, 80);
		apb(1'b1, 8'h24, 32'hc3);
		apb(1'b1, 8'h24, 32'h43);
		apb(1'b0, 8'h24, 0);
		chk(ok(rd[7]), 1);
		wait_for(0, 100, n);
		chk(ok(n >= 44 && n <= 64), 1);
		t0 = 0;
		while (mcu_reset_req === 1'b1 && t0 < 99) begin
			@(negedge clk);
			t0++;
		end
		chk(t0, 63);
		sys_reset();
		apb(1'b0, 8'h24, 0);
		chk(rd, 32'h7f);
		apb(1'b1, 8'h24, 32'ha0);
		wait_for(0, 5, n);
		chk(ok(n <= 3), 1);
		hw_opt <= 1'b1;
		sys_reset();
		wait_for(0, 1400, n);
		chk(ok(n >= 1250 && n <= 1300), 1);
		hw_opt <= 1'b0;
		hr_opt <= 1'b1;
		sys_reset();
		repeat (300) @(posedge clk);
		pulse(1'b0);
		wait_for(0, 5, n);
		chk(ok(n <= 3), 1);
		hr_opt <= 1'b0;
		sys_reset();
		repeat (300) @(posedge clk);
		apb(1'b1, 8'h24, 32'hc2);
		pulse(1'b0);
		repeat (40) @(negedge clk);
		chk(ok(halted), 1);
		apb(1'b0, 8'h24, 0);
		t0 = rd;
		chk(ok(rd == 32'hc1 || rd == 32'hc0), 1);
		repeat (100) @(posedge clk);
		apb(1'b0, 8'h24, 0);
		chk(rd, t0);
		pulse(1'b1);
		wait_for(0, 320, n);
		chk(ok(n >= 250 && n <= 300), 1);
		sys_reset();
		repeat (300) @(posedge clk);
		apb(1'b1, 8'h24, 32'h70);
		apb(1'b1, 8'h28, 32'h02);
		pulse(1'b0);
		apb(1'b0, 8'h24, 0);
		t0 = rd;
		repeat (60) @(negedge clk);
		chk({30'h0, active_halted, timebase_irq}, 2);
		apb(1'b0, 8'h24, 0);
		chk(rd, t0);
		@(posedge clk);
		irq_mask <= 1'b0;
		wait_for(2, 5, n);
		chk(ok(n <= 2), 1);
		repeat (40) @(posedge clk);
		apb(1'b0, 8'h24, 0);
		chk(ok(rd[6:0] < t0[6:0]), 1);
		irq_mask <= 1'b1;
		pulse(1'b0);
		@(negedge clk);
		chk(ok(active_halted), 1);
		pulse(1'b1);
		wait_for(2, 5, n);
		chk(ok(n <= 2), 1);
		irq_mask <= 1'b0;
		// The first rise after a select change may still close the old period.
		for (int s = 0; s < 4; s++) begin
			apb(1'b1, 8'h28, {28'h0, 2'(s), 2'b10});
			wait_for(1, 99, n);
			apb(1'b0, 8'h28, 0);
			wait_for(1, 99, n);
			t0 = cyc;
			apb(1'b0, 8'h28, 0);
			chk(ok(rd[0]), 1);
			wait_for(1, 99, n);
			chk(cyc - t0, TBP[s]);
		end
		// The long restart delay holds the counter for 4096 cycles after reset.
		dl_opt <= 1'b1;
		sys_reset();
		repeat (3900) @(posedge clk);
		apb(1'b0, 8'h24, 0);
		chk(rd, 32'h7f);
		repeat (400) @(posedge clk);
		apb(1'b0, 8'h24, 0);
		chk(ok(rd[6:0] != 7'h7f), 1);
		dl_opt <= 1'b0;
		results();
	end
endmodule : wdg_timebase_tb_top

`default_nettype wire
